// ### core/dfu_unpack.sv
/*
  Double floating operand unpacker: registers the decoded fields of a
  64-bit operand one clock after its valid strobe. A normal or zero
  operand answers with out_valid; a reserved operand answers with
  fault_req instead, and its fields are still loaded so that the
  exception logic can see what was refused. The fields stand until the
  next operand is taken. The file also holds the checks that guard the
  decode, the strobes and the reset values.
  Assumes the operand fetch path drives operand and in_valid on clk and
  that the exception logic acts on fault_req. Operands may arrive back
  to back on every clock; nothing is ever dropped or stalled, so the
  producer needs no ready signal. The true exponent output carries no
  meaning while the stored exponent is zero.
*/
`include "dfu_map.svh"
module dfu_unpack
  import dfu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        in_valid,
  input  wire logic [63:0] operand,
  output logic             out_valid,
  output logic             sign,
  output logic [7:0]       exp,
  output logic signed [8:0] true_exp,
  output logic [55:0]      frac,
  output logic             zero,
  output logic             rsvd,
  output logic             fault_req
);
  dfu_dec_t dec_w;
  dfu_dec_t dec_q;
  logic     vld_q;
  logic     flt_q;

  dfu_field_split u_split (
    .operand (operand),
    .dec     (dec_w)
  );

  // Fields are loaded on every strobe, a faulted operand included, so a fault
  // replaces the fields that the last good operand left for the arithmetic.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dec_q <= '{sign: 1'b0, exp: `DFU_RST_EXP, true_exp: 9'sh000,
                 frac: `DFU_RST_FRAC, zero: 1'b0, rsvd: 1'b0};
      vld_q <= 1'b0;
      flt_q <= 1'b0;
    end else begin
      if (in_valid) begin
        dec_q <= dec_w;
      end
      vld_q <= in_valid && !dec_w.rsvd;
      flt_q <= in_valid && dec_w.rsvd;
    end
  end

  assign out_valid = vld_q;
  assign fault_req = flt_q;
  assign sign      = dec_q.sign;
  assign exp       = dec_q.exp;
  assign true_exp  = dec_q.true_exp;
  assign frac      = dec_q.frac;
  assign zero      = dec_q.zero;
  assign rsvd      = dec_q.rsvd;

  valid_follows_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && !dec_w.rsvd |=> out_valid && !fault_req)
    else $error("output strobe missing after valid operand");
  fault_follows_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && dec_w.rsvd |=> fault_req && !out_valid && rsvd)
    else $error("reserved operand did not fault");
  no_spurious_a: assert property (@(posedge clk) disable iff (!rst_b)
    !in_valid |=> !out_valid && !fault_req)
    else $error("strobe without input");
  sign_field_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid |=> sign == $past(operand[15]))
    else $error("sign bit wrong");
  exp_field_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid |=> exp == $past(operand[14:7]))
    else $error("exponent field wrong");
  frac_order_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid |=> frac[54:0] == $past({operand[6:0], operand[31:16],
                                      operand[47:32], operand[63:48]}))
    else $error("fraction order wrong");
  hidden_bit_a: assert property (@(posedge clk) disable iff (!rst_b)
    out_valid |-> frac[55])
    else $error("hidden bit missing");
  true_exp_a: assert property (@(posedge clk) disable iff (!rst_b)
    out_valid && !zero |-> true_exp == $signed({1'b0, exp}) - 9'sd128)
    else $error("true exponent wrong");
  zero_class_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid |=> zero == ($past(operand[14:7]) == 8'h00 && !$past(operand[15])))
    else $error("zero classification wrong");
  hold_fields_a: assert property (@(posedge clk) disable iff (!rst_b)
    !in_valid |=> $stable(frac) && $stable(exp) && $stable(sign))
    else $error("fields changed without strobe");

  // Shadow of the last operand taken, kept only for the checks below, so
  // that every held field can be compared with its source at any cycle
  // and not only in the cycle just after a strobe.
  logic [63:0] chk_op_q;
  logic        chk_any_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chk_op_q  <= 64'h0000000000000000;
      chk_any_q <= 1'b0;
    end else if (in_valid) begin
      chk_op_q  <= operand;
      chk_any_q <= 1'b1;
    end
  end

  // Reset is checked without a disable, since it is the reset itself
  // that must clear every output.
  reset_clear_a: assert property (@(posedge clk)
    !rst_b |=> !out_valid && !fault_req && !sign && !zero && !rsvd &&
               exp == `DFU_RST_EXP && frac == `DFU_RST_FRAC)
    else $error("outputs not cleared by reset");

  held_sign_a: assert property (@(posedge clk) disable iff (!rst_b)
    chk_any_q |-> sign == chk_op_q[15])
    else $error("held sign differs from operand");

  held_exp_a: assert property (@(posedge clk) disable iff (!rst_b)
    chk_any_q |-> exp == chk_op_q[14:7])
    else $error("held exponent differs from operand");

  held_frac_a: assert property (@(posedge clk) disable iff (!rst_b)
    chk_any_q |-> frac[54:0] == {chk_op_q[6:0], chk_op_q[31:16],
                                 chk_op_q[47:32], chk_op_q[63:48]})
    else $error("held fraction differs from operand");

  held_hidden_a: assert property (@(posedge clk) disable iff (!rst_b)
    chk_any_q |-> frac[55])
    else $error("held fraction lost its hidden bit");

  held_texp_a: assert property (@(posedge clk) disable iff (!rst_b)
    chk_any_q |-> true_exp == $signed({1'b0, chk_op_q[14:7]}) - 9'sd128)
    else $error("held true exponent wrong");

  held_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    chk_any_q |-> zero == (chk_op_q[14:7] == 8'h00 && !chk_op_q[15]))
    else $error("held zero flag wrong");

  held_rsvd_a: assert property (@(posedge clk) disable iff (!rst_b)
    chk_any_q |-> rsvd == (chk_op_q[14:7] == 8'h00 && chk_op_q[15]))
    else $error("held reserved flag wrong");

  rsvd_class_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid |=> rsvd == ($past(operand[14:7]) == 8'h00 &&
                          $past(operand[15])))
    else $error("reserved classification wrong");

  class_excl_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(zero && rsvd))
    else $error("zero and reserved both set");

  zero_code_a: assert property (@(posedge clk) disable iff (!rst_b)
    zero |-> exp == 8'h00 && !sign)
    else $error("zero flag on a nonzero code");

  rsvd_code_a: assert property (@(posedge clk) disable iff (!rst_b)
    rsvd |-> exp == 8'h00 && sign)
    else $error("reserved flag on a wrong code");

  normal_code_a: assert property (@(posedge clk) disable iff (!rst_b)
    exp != 8'h00 |-> !zero && !rsvd)
    else $error("normal code flagged special");

  zero_valid_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && dec_w.zero |=> out_valid && zero)
    else $error("zero operand not delivered");

  strobe_excl_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(out_valid && fault_req))
    else $error("valid and fault strobes together");

  valid_source_a: assert property (@(posedge clk) disable iff (!rst_b)
    out_valid |-> $past(in_valid) && !rsvd)
    else $error("output strobe without a normal operand");

  fault_source_a: assert property (@(posedge clk) disable iff (!rst_b)
    fault_req |-> $past(in_valid) && rsvd)
    else $error("fault without a reserved operand");

  back_to_back_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid ##1 in_valid |=> out_valid || fault_req)
    else $error("second of two operands lost");

  // A faulted operand must not leave a stale zero flag or exponent behind.
  fault_fields_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && dec_w.rsvd |=> sign && exp == 8'h00 && !zero)
    else $error("faulted operand fields wrong");

  flags_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !in_valid |=> $stable(rsvd) && $stable(zero) && $stable(true_exp))
    else $error("flags changed without strobe");
endmodule : dfu_unpack

// ### include/dfu_map.svh
/*
  Constants for the double floating unpacker: field positions, widths,
  bias and reset values.
  Assumes it is included by its bare name after the package is compiled.
*/
// Summary of operation
// - The unit takes an eight-byte operand with bits numbered 0 to 63 from the right.
// - The sign is operand bit 15, given out on its own output.
// - The 8-bit exponent is operand bits 14 down to 7, biased by 128.
// - The rest is a 56-bit normalized fraction whose hidden top bit is supplied.
// - The fraction runs from bits 6..0, then 31..16, 47..32, and 63..48.
// - Exponent codes 1 to 255 mean true exponents from -127 up to 127.
// - A zero exponent with a clear sign is reported as exactly zero.
// - A zero exponent with a set sign is reserved and raises a reserved operand fault.
// - A fault leaves all state consistent so the instruction can be restarted.
`ifndef DFU_MAP_SVH
`define DFU_MAP_SVH
`define DFU_SIGN_BIT      15
`define DFU_EXP_HI        14
`define DFU_EXP_LO        7
`define DFU_EXP_BIAS      9'sh080
`define DFU_FRAC_W        56
`define DFU_RST_EXP       8'h00
`define DFU_RST_FRAC      56'h00000000000000
`endif

// ### include/dfu_pkg.sv
/*
  Types shared by the double floating unpacker.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dfu_pkg;
  typedef struct packed {
    logic        sign;
    logic [7:0]  exp;
    logic signed [8:0] true_exp;
    logic [55:0] frac;
    logic        zero;
    logic        rsvd;
  } dfu_dec_t;
endpackage : dfu_pkg

// ### core/dfu_field_split.sv
/*
  Combinational split of a double floating operand into its fields.
  Assumes the operand is stable in the cycle it is flagged valid.
*/
`include "dfu_map.svh"
module dfu_field_split
  import dfu_pkg::*;
(
  input  wire logic [63:0] operand,
  output dfu_dec_t         dec
);
  wire logic        sign_w;
  wire logic [7:0]  exp_w;
  wire logic [54:0] stored_frac_w;

  assign sign_w = operand[`DFU_SIGN_BIT];
  assign exp_w  = operand[`DFU_EXP_HI:`DFU_EXP_LO];
  assign stored_frac_w = {operand[6:0], operand[31:16],
                          operand[47:32], operand[63:48]};

  assign dec.sign     = sign_w;
  assign dec.exp      = exp_w;
  // A zero code has no true exponent; the arithmetic never reads it then.
  assign dec.true_exp = $signed({1'b0, exp_w}) - `DFU_EXP_BIAS;
  assign dec.frac     = {1'b1, stored_frac_w};
  assign dec.zero     = (exp_w == 8'h00) && !sign_w;
  assign dec.rsvd     = (exp_w == 8'h00) && sign_w;
endmodule : dfu_field_split

// ### bench/dfu_src_model.sv
/*
  Operand fetch model that hands the unpacker one operand for each clock in which go is high.
  Assumes go and d change just after a rising edge of clk.
*/
module dfu_src_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [63:0] d,
  output logic             in_valid = 1'b0,
  output logic [63:0]      operand  = 64'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Between operands the bus flips, so stale data cannot pass for new data.
  always @(posedge clk) begin
    in_valid <= go;
    operand  <= go ? d : ~operand;
  end
endmodule : dfu_src_model

// ### bench/double_float_unpacker_test.sv
/*
  Self-checking bench for the double floating unpacker.
  Assumes the unpacker answers one clock after it takes an operand.
*/
module double_float_unpacker_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk, rst_b, go, in_valid, out_valid;
  logic              sign, zero, rsvd, fault_req;
  logic [63:0]       d, operand;
  logic [7:0]        exp;
  logic signed [8:0] true_exp;
  logic [55:0]       frac;
  int                errors, n_tests;
  dfu_src_model src (.clk, .go, .d, .in_valid, .operand);
  dfu_unpack DUT (.clk, .rst_b, .in_valid, .operand, .out_valid, .sign,
                  .exp, .true_exp, .frac, .zero, .rsvd, .fault_req);
  function automatic logic [77:0] want_of(input logic [63:0] op);
    logic       s, z, r;
    logic [7:0] e;
    s = op[15];
    e = op[14:7];
    z = (e == 8'h00) & ~s;
    r = (e == 8'h00) & s;
    return {~r, r, s, e, {1'b0, e} - 9'h080, 1'b1, op[6:0], op[31:16],
            op[47:32], op[63:48], z, r};
  endfunction : want_of
  task check(input logic [77:0] want);
    logic [77:0] got;
    got = {out_valid, fault_req, sign, exp, true_exp, frac, zero, rsvd};
    n_tests++;
    if (got !== want) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask : check
  task send(input logic [63:0] op);
    @(posedge clk) begin
      go <= 1'b1;
      d  <= op;
    end
    @(posedge clk) go <= 1'b0;
    @(posedge clk) #1;
    check(want_of(op));
  endtask : send
  task t_hold;
    logic [77:0] w;
    w = want_of(64'h0123_4567_89ab_4c5d);
    send(64'h0123_4567_89ab_4c5d);
    repeat (2) begin
      @(posedge clk) #1;
      check({2'b00, w[75:0]});
    end
  endtask : t_hold
  task t_back;
    @(posedge clk) begin
      go <= 1'b1;
      d  <= 64'h1111_2222_3333_807f;
    end
    @(posedge clk) d <= 64'hfedc_ba98_7654_7fff;
    @(posedge clk) go <= 1'b0;
    #1;
    check(want_of(64'h1111_2222_3333_807f));
    @(posedge clk) #1;
    check(want_of(64'hfedc_ba98_7654_7fff));
  endtask : t_back
  task t_reset;
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(78'h0);
    @(posedge clk) rst_b <= 1'b1;
    send(64'h5555_aaaa_0f0f_0080);
  endtask : t_reset
  task t_norm;
    send(64'h0123_4567_89ab_4c5d);
    send(64'hfedc_ba98_7654_7fff);
    send(64'h5555_aaaa_0f0f_0080);
  endtask : t_norm
  task t_zero;
    send(64'hdead_beef_cafe_007f);
  endtask : t_zero
  task t_rsvd;
    send(64'h1111_2222_3333_807f);
    send(64'h9999_8888_7777_c3a1);
  endtask : t_rsvd
  task results;
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #20000;
    errors++;
    results();
  end
  initial begin
    rst_b = 1'b0;
    go = 1'b0;
    d = 64'h0;
    errors = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_norm();
    t_hold();
    t_zero();
    t_rsvd();
    t_back();
    t_reset();
    results();
  end
endmodule : double_float_unpacker_test
